/* File: logic/ewc_pkg.sv */
// Constants, field layout and helpers shared by the ephemeris word codec.
// Assumes one 250 MHz clock and a 20 ms navigation bit period.
package ewc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_PERIOD_MS = 20;
  localparam int BIT_CYCLES_DEF = (BIT_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CNT_W = 32;
  localparam logic [6:0] STRING_TICKS = 7'h64;
  localparam logic [6:0] DATA_TICKS = 7'h55;
  localparam logic [3:0] FRAME_STRINGS = 4'hf;
  localparam logic [2:0] SF_FRAMES = 3'h5;

  // ****************************************************************
  // Word widths
  // ****************************************************************
  localparam int STR_BITS = 85;
  localparam int W_STR = 4;
  localparam int W_HOUR = 5;
  localparam int W_MIN = 6;
  localparam int W_TOD = 12;
  localparam int W_TB = 7;
  localparam int W_UPD = 2;
  localparam int W_GAMMA = 11;
  localparam int W_TAU = 22;
  localparam int W_DTAU = 5;
  localparam int W_POS = 27;
  localparam int W_VEL = 24;
  localparam int W_ACC = 5;
  localparam int W_HW = 3;
  localparam int W_DAY = 11;
  localparam int W_SLOT = 5;
  localparam int W_ACCY = 4;
  localparam int W_MOD = 2;
  localparam logic [W_HOUR-1:0] HOUR_MAX = 5'h17;
  localparam logic [W_MIN-1:0] MIN_MAX = 6'h3b;
  localparam logic [W_ACCY-1:0] ACCY_UNUSED = 4'hf;

  // ****************************************************************
  // Bit numbers of the least significant bit of each word in a string
  // ****************************************************************
  localparam int P_STRNUM = 81;
  localparam int P_UPD = 77;
  localparam int P_TOD = 65;
  localparam int P_VEL = 41;
  localparam int P_ACC = 36;
  localparam int P_POS = 9;
  localparam int P_HW = 78;
  localparam int P_PAR = 77;
  localparam int P_TB = 70;
  localparam int P_ALM = 80;
  localparam int P_GAMMA = 69;
  localparam int P_CSRC = 66;
  localparam int P_SATH = 65;
  localparam int P_TAU = 59;
  localparam int P_DTAU = 54;
  localparam int P_EPH = 34;
  localparam int P_ACCY = 30;
  localparam int P_DAY = 16;
  localparam int P_SLOT = 11;
  localparam int P_MOD = 9;
  localparam int P_SATH_ALM = 9;

  // ****************************************************************
  // Register map (word index on the register port)
  // ****************************************************************
  localparam int N_REGS = 15;
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_TIME = 4'h1;
  localparam logic [3:0] R_GAMMA = 4'h2;
  localparam logic [3:0] R_TAU = 4'h3;
  localparam logic [3:0] R_DTAU = 4'h4;
  localparam logic [3:0] R_POS = 4'h5;
  localparam logic [3:0] R_VEL = 4'h8;
  localparam logic [3:0] R_ACC = 4'hb;
  localparam logic [3:0] R_STATUS = 4'he;
  localparam logic [31:0] REG_RESET = 32'h0;

  // Control register fields.
  localparam int C_EN = 0;
  localparam int C_CSRC = 1;
  localparam int C_ALM = 2;
  localparam int C_EPH = 3;
  localparam int C_MOD = 4;
  localparam int C_HW = 6;
  localparam int C_SATH = 9;
  localparam int C_UPD = 10;
  localparam int C_ACCY = 12;

  // Time register fields.
  localparam int T_TB = 0;
  localparam int T_SLOT = 7;
  localparam int T_DAY = 12;

  // Status register fields.
  localparam int S_TOD = 0;
  localparam int S_STR = 12;
  localparam int S_FRM = 16;

  // Update-interval codes whose spacing makes the parity flag meaningful.
  localparam logic [W_UPD-1:0] UPD_30 = 2'h1;
  localparam logic [W_UPD-1:0] UPD_60 = 2'h3;

  // Two's complement to sign-magnitude of width w, magnitude saturated.
  function automatic logic [31:0] sign_mag(input logic [31:0] v, input int w);
    logic neg;
    logic [31:0] mag;
    logic [31:0] lim;
    neg = v[31];
    mag = neg ? (~v + 32'h1) : v;
    lim = (32'h1 << (w - 1)) - 32'h1;
    if (mag > lim)
    begin
      mag = lim;
    end
    sign_mag = mag | ({31'h0, neg} << (w - 1));
  endfunction

endpackage

/* File: logic/ewc_tod_counter.sv */
// Time-of-frame counter: hours, minutes and a 30 s half-minute bit.
// Assumes frame_tick pulses once per 30 s frame and day_clear at a day start.
`timescale 1ns/10ps
module ewc_tod_counter
  import ewc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Events
  input wire logic frame_tick,
  input wire logic day_clear,
  // Time of frame word
  output logic [W_TOD-1:0] frame_time_of_day
);

  typedef struct packed {
    logic [W_HOUR-1:0] hour;
    logic [W_MIN-1:0] minute;
    logic half;
  } ewc_tod_t;

  ewc_tod_t st_reg;
  ewc_tod_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (day_clear)
    begin
      st_next = '0;
    end
    else if (frame_tick)
    begin
      st_next.half = ~st_reg.half;
      if (st_reg.half)
      begin
        if (st_reg.minute == MIN_MAX)
        begin
          st_next.minute = '0;
          st_next.hour = (st_reg.hour == HOUR_MAX) ? '0 : st_reg.hour + 5'h1;
        end
        else
        begin
          st_next.minute = st_reg.minute + 6'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign frame_time_of_day = {st_reg.hour, st_reg.minute, st_reg.half};

endmodule

/* File: logic/ewc_string_shifter.sv */
// Serialiser for one 85-bit string, highest bit number sent first.
// Assumes load and shift come as one-cycle pulses from the bit timing logic.
`timescale 1ns/10ps
module ewc_string_shifter
  import ewc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic shift,
  input wire logic [STR_BITS-1:0] string_in,
  // Serial data
  output logic bit_out
);

  typedef struct packed {
    logic [STR_BITS-1:0] sr;
  } ewc_shift_t;

  ewc_shift_t st_reg;
  ewc_shift_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (load)
    begin
      st_next.sr = string_in;
    end
    else if (shift)
    begin
      st_next.sr = {st_reg.sr[STR_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bit_out = st_reg.sr[STR_BITS-1];

endmodule

/* File: logic/ewc_codec.sv */
// Message generator for the immediate words of strings 1 to 15 of a frame.
// Assumes a register port master on mclk and a day mark pin from the time scale.
`timescale 1ns/10ps

// What this block does
// - Signed words carry sign in the MSB, 0 positive, 1 negative, then magnitude.
// - String number is a 4-bit unsigned position within the frame.
// - Time of frame holds whole hours 0 to 23 in its five MSBs.
// - Next six bits hold whole minutes 0 to 59.
// - Lowest bit counts a 30 second half minute.
// - Time of frame runs on satellite time; day starts with a superframe.
// - Reference interval index is 7 bits weighted 15 minutes.
// - Correction source flag is 1 onboard, 0 when uploaded from ground.
// - Update interval code 00,01,10,11 means 0,30,45,60 minutes.
// - For 30 or 60 minute spacing, parity flag is index odd.
// - Almanac count flag is 1 for five satellites, 0 for four.
// - Ephemeris update flag is 1 when fresh ephemeris is carried.
// - Day number is an 11-bit day within a four-year cycle.
// - Transmitter index is the 5-bit constellation slot number.
// - Accuracy code is 4 bits; code 15 is never used.
// - Modification flag 00 first generation, 01 modernised satellite.
// - Satellite health bit is 1 for malfunction.
// - Frequency deviation is 11-bit signed, LSB 2 to the minus 40.
// - Clock correction is 22-bit signed seconds, LSB 2 to the minus 30.
// - Inter-band delay is 5-bit signed seconds, LSB 2 to the minus 30.
// - Words go MSB first; data occupy string bits 9 to 84.
module ewc_codec
  import ewc_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Day start mark from the satellite time scale
  input wire logic day_mark,
  // Navigation stream
  output logic nav_data,
  output logic nav_bit_strobe,
  output logic time_mark,
  output logic string_start
);

  typedef struct packed {
    logic [N_REGS-1:0][31:0] regs;
    logic [2:0] mark_sync;
    logic mark_level;
    logic [CNT_W-1:0] div_cnt;
    logic [6:0] tick_cnt;
    logic [W_STR-1:0] str_num;
    logic [2:0] frame_num;
    logic running;
    logic [31:0] rdata;
    logic nav_data;
    logic nav_bit_strobe;
    logic time_mark;
    logic string_start;
  } ewc_state_t;

  ewc_state_t st_reg;
  ewc_state_t st_next;

  logic [W_TOD-1:0] frame_time_of_day;
  logic shifter_bit;
  logic bit_tick;
  logic load_str;
  logic frame_tick;
  logic day_clear;
  logic [STR_BITS-1:0] string_word;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  logic enable;
  logic correction_source;
  logic almanac_count_flag;
  logic ephemeris_update_flag;
  logic [W_MOD-1:0] modification_flag;
  logic [W_HW-1:0] health_word;
  logic sat_health_bit;
  logic [W_UPD-1:0] update_interval_code;
  logic [W_ACCY-1:0] accuracy_code;
  logic [W_TB-1:0] reference_interval_index;
  logic [W_SLOT-1:0] slot_index;
  logic [W_DAY-1:0] day_in_cycle;
  logic interval_parity_flag;

  assign enable = st_reg.regs[R_CTRL][C_EN];
  assign correction_source = st_reg.regs[R_CTRL][C_CSRC];
  assign almanac_count_flag = st_reg.regs[R_CTRL][C_ALM];
  assign ephemeris_update_flag = st_reg.regs[R_CTRL][C_EPH];
  assign modification_flag = st_reg.regs[R_CTRL][C_MOD +: W_MOD];
  assign health_word = st_reg.regs[R_CTRL][C_HW +: W_HW];
  assign sat_health_bit = st_reg.regs[R_CTRL][C_SATH];
  assign update_interval_code = st_reg.regs[R_CTRL][C_UPD +: W_UPD];
  assign accuracy_code = st_reg.regs[R_CTRL][C_ACCY +: W_ACCY];
  assign reference_interval_index = st_reg.regs[R_TIME][T_TB +: W_TB];
  assign slot_index = st_reg.regs[R_TIME][T_SLOT +: W_SLOT];
  assign day_in_cycle = st_reg.regs[R_TIME][T_DAY +: W_DAY];

  // Parity only carries meaning for 30 or 60 minute spacing.
  assign interval_parity_flag = ((update_interval_code == UPD_30) ||
                                 (update_interval_code == UPD_60)) &&
                                reference_interval_index[0];

  // ****************************************************************
  // Bit timing
  // ****************************************************************
  assign bit_tick = st_reg.running && (st_reg.div_cnt == CNT_W'(BIT_CYCLES - 1));
  assign load_str = bit_tick && (st_reg.tick_cnt == 7'h0);
  assign frame_tick = bit_tick && (st_reg.tick_cnt == STRING_TICKS - 7'h1) &&
                      (st_reg.str_num == FRAME_STRINGS);
  // Day mark counts once the second and third sync stages agree on a new high level.
  assign day_clear = (st_reg.mark_sync[1] == st_reg.mark_sync[2]) &&
                     st_reg.mark_sync[2] && !st_reg.mark_level;

  // ****************************************************************
  // String assembly
  // ****************************************************************
  always_comb
  begin
    logic [1:0] axis;
    logic [31:0] pos_sm;
    logic [31:0] vel_sm;
    logic [31:0] acc_sm;
    logic [31:0] gam_sm;
    logic [31:0] tau_sm;
    logic [31:0] dtau_sm;
    axis = 2'h0;
    pos_sm = 32'h0;
    vel_sm = 32'h0;
    acc_sm = 32'h0;
    gam_sm = sign_mag(st_reg.regs[R_GAMMA], W_GAMMA);
    tau_sm = sign_mag(st_reg.regs[R_TAU], W_TAU);
    dtau_sm = sign_mag(st_reg.regs[R_DTAU], W_DTAU);
    string_word = '0;
    string_word[P_STRNUM-1 +: W_STR] = st_reg.str_num;
    if ((st_reg.str_num != 4'h0) && (st_reg.str_num < 4'h4))
    begin
      axis = st_reg.str_num[1:0] - 2'h1;
      pos_sm = sign_mag(st_reg.regs[R_POS + 4'(axis)], W_POS);
      vel_sm = sign_mag(st_reg.regs[R_VEL + 4'(axis)], W_VEL);
      acc_sm = sign_mag(st_reg.regs[R_ACC + 4'(axis)], W_ACC);
      string_word[P_POS-1 +: W_POS] = pos_sm[W_POS-1:0];
      string_word[P_ACC-1 +: W_ACC] = acc_sm[W_ACC-1:0];
      string_word[P_VEL-1 +: W_VEL] = vel_sm[W_VEL-1:0];
    end
    case (st_reg.str_num)
      4'h1:
      begin
        string_word[P_TOD-1 +: W_TOD] = frame_time_of_day;
        string_word[P_UPD-1 +: W_UPD] = update_interval_code;
      end
      4'h2:
      begin
        string_word[P_TB-1 +: W_TB] = reference_interval_index;
        string_word[P_PAR-1] = interval_parity_flag;
        string_word[P_HW-1 +: W_HW] = health_word;
      end
      4'h3:
      begin
        string_word[P_SATH-1] = sat_health_bit;
        string_word[P_CSRC-1] = correction_source;
        string_word[P_GAMMA-1 +: W_GAMMA] = gam_sm[W_GAMMA-1:0];
        string_word[P_ALM-1] = almanac_count_flag;
      end
      4'h4:
      begin
        string_word[P_MOD-1 +: W_MOD] = modification_flag;
        string_word[P_SLOT-1 +: W_SLOT] = slot_index;
        string_word[P_DAY-1 +: W_DAY] = day_in_cycle;
        string_word[P_ACCY-1 +: W_ACCY] = accuracy_code;
        string_word[P_EPH-1] = ephemeris_update_flag;
        string_word[P_DTAU-1 +: W_DTAU] = dtau_sm[W_DTAU-1:0];
        string_word[P_TAU-1 +: W_TAU] = tau_sm[W_TAU-1:0];
      end
      default:
      begin
        // Odd almanac strings repeat the transmitter's own health bit.
        if (st_reg.str_num[0] && (st_reg.str_num > 4'h4))
        begin
          string_word[P_SATH_ALM-1] = sat_health_bit;
        end
      end
    endcase
  end

  // ****************************************************************
  // State update
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.mark_sync = {st_reg.mark_sync[1:0], day_mark};
    if (st_reg.mark_sync[1] == st_reg.mark_sync[2])
    begin
      st_next.mark_level = st_reg.mark_sync[2];
    end
    st_next.nav_bit_strobe = 1'b0;
    st_next.string_start = 1'b0;

    // Register writes; an accuracy code of 15 keeps the previous code.
    if (reg_wr && (reg_addr < R_STATUS))
    begin
      st_next.regs[reg_addr] = reg_wdata;
      if ((reg_addr == R_CTRL) && (reg_wdata[C_ACCY +: W_ACCY] == ACCY_UNUSED))
      begin
        st_next.regs[R_CTRL][C_ACCY +: W_ACCY] = accuracy_code;
      end
    end
    st_next.rdata = 32'h0;
    if (reg_rd)
    begin
      if (reg_addr == R_STATUS)
      begin
        st_next.rdata[S_TOD +: W_TOD] = frame_time_of_day;
        st_next.rdata[S_STR +: W_STR] = st_reg.str_num;
        st_next.rdata[S_FRM +: 3] = st_reg.frame_num;
      end
      else if (reg_addr < R_STATUS)
      begin
        st_next.rdata = st_reg.regs[reg_addr];
      end
    end

    if (day_clear && enable)
    begin
      // A day start is a superframe start: restart at string 1 of frame 1.
      st_next.running = 1'b1;
      st_next.div_cnt = '0;
      st_next.tick_cnt = 7'h0;
      st_next.str_num = 4'h1;
      st_next.frame_num = 3'h1;
    end
    else if (!enable)
    begin
      st_next.running = 1'b0;
      st_next.time_mark = 1'b0;
    end
    else if (st_reg.running)
    begin
      st_next.div_cnt = bit_tick ? '0 : st_reg.div_cnt + CNT_W'(1);
      if (bit_tick)
      begin
        st_next.nav_bit_strobe = st_reg.tick_cnt < DATA_TICKS;
        st_next.time_mark = st_reg.tick_cnt >= DATA_TICKS;
        st_next.string_start = load_str;
        st_next.nav_data = load_str ? string_word[STR_BITS-1] : shifter_bit;
        if (st_reg.tick_cnt == STRING_TICKS - 7'h1)
        begin
          st_next.tick_cnt = 7'h0;
          if (st_reg.str_num == FRAME_STRINGS)
          begin
            st_next.str_num = 4'h1;
            st_next.frame_num = (st_reg.frame_num == SF_FRAMES) ? 3'h1 :
                                st_reg.frame_num + 3'h1;
          end
          else
          begin
            st_next.str_num = st_reg.str_num + 4'h1;
          end
        end
        else
        begin
          st_next.tick_cnt = st_reg.tick_cnt + 7'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.str_num <= 4'h1;
      st_reg.frame_num <= 3'h1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  ewc_tod_counter u_tod (
    .mclk(mclk),
    .rst_n(rst_n),
    .frame_tick(frame_tick),
    .day_clear(day_clear && enable),
    .frame_time_of_day(frame_time_of_day)
  );

  // The shifter holds the string from its second bit on.
  ewc_string_shifter u_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(load_str),
    .shift(bit_tick && !load_str),
    .string_in({string_word[STR_BITS-2:0], 1'b0}),
    .bit_out(shifter_bit)
  );

  assign reg_rdata = st_reg.rdata;
  assign nav_data = st_reg.nav_data;
  assign nav_bit_strobe = st_reg.nav_bit_strobe;
  assign time_mark = st_reg.time_mark;
  assign string_start = st_reg.string_start;

endmodule

/* File: tb/ewc_receiver.sv */
// Receiver model: rebuilds each 85-bit string from the serial stream.
// Assumes nav_data is valid in the cycle where nav_bit_strobe is high.
`timescale 1ns/10ps
module ewc_receiver
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial stream
  input wire logic nav_data,
  input wire logic nav_bit_strobe,
  input wire logic string_start,
  // Decoded string
  output logic [84:0] rx_string,
  output logic rx_done,
  output logic rx_fault
);
  logic [83:0] sh;
  logic [6:0] cnt;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh <= 84'h0;
      cnt <= 7'h0;
      rx_string <= 85'h0;
      rx_done <= 1'b0;
      rx_fault <= 1'b0;
    end
    else
    begin
      rx_done <= nav_bit_strobe && !string_start && cnt == 7'h54;
      if (nav_bit_strobe)
      begin
        sh <= {sh[82:0], nav_data};
        cnt <= string_start ? 7'h1 : cnt + 7'h1;
      end
      if (nav_bit_strobe && !string_start && cnt == 7'h54)
      begin
        rx_string <= {sh, nav_data};
      end
      // Only the top bit of the health word counts; the other two are ignored.
      if (rx_done && rx_string[83:80] == 4'h2)
      begin
        rx_fault <= rx_string[79];
      end
    end
  end
endmodule

/* File: tb/ewc_codec_properties.sv */
// Concurrent checks on the ports of the codec.
// Assumes it is bound to ewc_codec with BIT_CYCLES handed on.
`timescale 1ns/10ps
module ewc_codec_checker
  import ewc_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Stream
  input wire logic day_mark,
  input wire logic nav_data,
  input wire logic nav_bit_strobe,
  input wire logic time_mark,
  input wire logic string_start
);
  logic [6:0] bits;
  logic [31:0] gap;
  // Counts data bits of the current string and cycles since the last bit.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bits <= 7'h0;
      gap <= 32'h0;
    end
    else if (nav_bit_strobe)
    begin
      bits <= string_start ? 7'h1 : bits + 7'h1;
      gap <= 32'h0;
    end
    else
    begin
      gap <= gap + 32'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside a read cycle");
  chk_unmapped_read: assert property (reg_rd && reg_addr == 4'hf |=> reg_rdata == 32'h0)
    else $error("unmapped read gave data");
  chk_start_strobe: assert property (string_start |-> nav_bit_strobe)
    else $error("string start without bit strobe");
  chk_idle_chip: assert property (string_start |-> !nav_data)
    else $error("first bit of string not zero");
  chk_data_count: assert property ($rose(time_mark) |-> bits == 7'h55)
    else $error("mark began after wrong bit count");
  chk_mark_quiet: assert property (time_mark |-> !nav_bit_strobe)
    else $error("bit strobe during time mark");
  chk_bit_spacing: assert property (nav_bit_strobe && !string_start
    |-> gap == 32'(BIT_CYCLES - 1))
    else $error("bit strobes badly spaced");
  chk_pad_zero: assert property (nav_bit_strobe && !string_start && bits >= 7'h4d
    |-> !nav_data)
    else $error("check bit area not zero");
  cover property (string_start);
  cover property ($rose(time_mark));
  cover property (reg_rd && reg_addr == R_STATUS);
endmodule

bind ewc_codec ewc_codec_checker #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .day_mark(day_mark),
  .nav_data(nav_data), .nav_bit_strobe(nav_bit_strobe), .time_mark(time_mark),
  .string_start(string_start));

/* File: tb/test_ewc_codec.sv */
// Testbench: register writes, then four frames decoded and compared.
// Assumes the receiver model and the bound checker are compiled first.
`timescale 1ns/10ps
module test_ewc_codec
  import ewc_pkg::*;
;
  localparam int BC = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic day_mark = 1'b0;
  logic [31:0] reg_rdata;
  logic nav_data, nav_bit_strobe, time_mark, string_start;
  logic [84:0] rx_string;
  logic rx_done, rx_fault;
  logic [84:0] s;
  int bad_count = 0;
  int tests_run = 0;
  always #2 mclk = ~mclk;
  ewc_codec #(.BIT_CYCLES(BC)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .day_mark(day_mark),
    .nav_data(nav_data), .nav_bit_strobe(nav_bit_strobe), .time_mark(time_mark),
    .string_start(string_start));
  ewc_receiver rx_u (
    .mclk(mclk), .rst_n(rst_n), .nav_data(nav_data),
    .nav_bit_strobe(nav_bit_strobe), .string_start(string_start),
    .rx_string(rx_string), .rx_done(rx_done), .rx_fault(rx_fault));
  task automatic chk(input logic [84:0] got, input logic [84:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(85'(reg_rdata), 85'(e));
  endtask
  // Waits for the receiver to finish a string and copies it.
  task automatic get();
    int k;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (rx_done !== 1'b1 && k < 1000);
    chk(85'(rx_done), 85'h1);
    s = rx_string;
  endtask
  function automatic logic [84:0] fld(input int lo, input int w);
    fld = (s >> (lo - 1)) & ((85'h1 << w) - 85'h1);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial
  begin
    #160000;
    bad_count++;
    $display("unexpected at %0t: watchdog got %h expected %h", $time, 1'h0, 1'h1);
    complete_run();
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(R_CTRL, 32'h0);
    rd(R_TIME, 32'h0);
    rd(R_GAMMA, 32'h0);
    rd(R_STATUS, 32'h11000);
    wr(R_CTRL, 32'hf75f);
    rd(R_CTRL, 32'h075f);
    wr(R_TIME, 32'h5a18ab);
    rd(R_TIME, 32'h5a18ab);
    wr(R_GAMMA, 32'hfffffffd);
    wr(R_TAU, 32'hfffffffb);
    wr(R_DTAU, 32'h4);
    wr(R_POS, 32'hffffffff);
    wr(R_POS + 4'h1, 32'h7fffffff);
    wr(R_VEL, 32'h5);
    wr(R_ACC, 32'hfffffffe);
    wr(R_STATUS, 32'hffff);
    rd(R_STATUS, 32'h11000);
    rd(4'hf, 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      wr(R_CTRL, 32'he25f | (32'(f) << 10) | (32'(f % 2) << 8));
      // A second day mark cuts frame three short and restarts the superframe.
      if (f == 0 || f == 3)
      begin
        day_mark <= 1'b1;
        repeat (4) @(posedge mclk);
        day_mark <= 1'b0;
      end
      for (int n = 1; n < 16; n++)
      begin
        get();
        rd(R_STATUS, 32'(f % 3) | (32'(n) << S_STR) | (32'(f % 3 + 1) << S_FRM));
        if (n > 4)
        begin
          chk(s, (85'(n) << 80) | ((n % 2) ? 85'h100 : 85'h0));
        end
        else
        begin
          chk(fld(81, 4), 85'(n));
          chk({s[84], s[7:0]}, 85'h0);
        end
        case (n)
          1:
          begin
            chk(fld(77, 2), 85'(f));
            chk(fld(65, 12), 85'(f % 3));
            chk(fld(41, 24), 24'h5);
            chk(fld(36, 5), 5'h12);
            chk(fld(9, 27), 27'h4000001);
          end
          2:
          begin
            chk(fld(77, 1), 85'(f % 2));
            chk(fld(78, 3), 85'(((f % 2) << 2) | 1));
            chk(fld(70, 7), 7'h2b);
            chk(fld(9, 27), 27'h3ffffff);
          end
          3:
          begin
            chk(85'(rx_fault), 85'(f % 2));
            chk(fld(80, 1), 1'h1);
            chk(fld(69, 11), 11'h403);
            chk(fld(66, 1), 1'h1);
            chk(fld(65, 1), 1'h1);
            chk(fld(9, 27), 27'h0);
          end
          4:
          begin
            chk(fld(59, 22), 22'h200005);
            chk(fld(54, 5), 5'h4);
            chk(fld(34, 1), 1'h1);
            chk(fld(30, 4), 4'he);
            chk(fld(16, 11), 11'h5a1);
            chk(fld(11, 5), 5'h11);
            chk(fld(9, 2), 2'h1);
          end
          default:
          begin
          end
        endcase
      end
    end
    wr(R_CTRL, 32'he35e);
    repeat (8 * BC) @(posedge mclk);
    #1;
    chk({time_mark, nav_bit_strobe}, 85'h0);
    complete_run();
  end
endmodule
